//--- src/rtc_pkg.sv
// Package with register map, field positions, reset values and timing for the real-time clock block
//
// Overview of operation
// - Drive main supply low output at falling threshold
// - Release main supply low after release delay
// - Set power-on flag on power-up from zero
// - Power-on flag clears trim, control one, and control two except run and power-on bits
// - Keep sticky record of any oscillator halt longer than the watchdog timeout
// - Supply monitor threshold select, latch low record
// - Supply monitor samples once every second
// - Periodic interrupt offers six selectable rates
// - Pulse waveform for 2/1 Hz, else level
// - Periodic condition readable as status bit
// - Crystal clock output always running, undisableable
// - Sixteen registers, seconds at address zero
// - Unused bits ignore writes, read zero; control one bits 4 and 3 and control two bit 3 keep writes and read back
// - Month has century bit, year two digits
// - Trim register: step select plus trim value
// - Control one field layout, all reset zero
// - Alarm enable bits gate alarm interrupt circuits
// - Hour format select: 12-hour or 24-hour
// - Twelve-hour coding uses bit five for PM
// - Periodic select encoding of eight modes
// - Power-on flag cleared only by writing zero
// - Supply low flag stops monitor until cleared
package rtc_pkg;

  // Register addresses
  localparam logic [3:0] RTC_ADDR_SEC = 4'h0;
  localparam logic [3:0] RTC_ADDR_MIN = 4'h1;
  localparam logic [3:0] RTC_ADDR_HOUR = 4'h2;
  localparam logic [3:0] RTC_ADDR_WDAY = 4'h3;
  localparam logic [3:0] RTC_ADDR_MDAY = 4'h4;
  localparam logic [3:0] RTC_ADDR_MON = 4'h5;
  localparam logic [3:0] RTC_ADDR_YEAR = 4'h6;
  localparam logic [3:0] RTC_ADDR_TRIM = 4'h7;
  localparam logic [3:0] RTC_ADDR_WA_MIN = 4'h8;
  localparam logic [3:0] RTC_ADDR_WA_HOUR = 4'h9;
  localparam logic [3:0] RTC_ADDR_WA_DAYS = 4'hA;
  localparam logic [3:0] RTC_ADDR_DA_MIN = 4'hB;
  localparam logic [3:0] RTC_ADDR_DA_HOUR = 4'hC;
  localparam logic [3:0] RTC_ADDR_CTRL1 = 4'hE;
  localparam logic [3:0] RTC_ADDR_CTRL2 = 4'hF;

  // Control register 1 field positions
  localparam int RTC_C1_WALARM_EN = 7;
  localparam int RTC_C1_DALARM_EN = 6;
  localparam int RTC_C1_HOUR24 = 5;
  localparam int RTC_C1_PSEL_MSB = 2;

  // Control register 2 field positions
  localparam int RTC_C2_THR_SEL = 7;
  localparam int RTC_C2_SUPPLY_LOW = 6;
  localparam int RTC_C2_OSC_RUN = 5;
  localparam int RTC_C2_PON = 4;
  localparam int RTC_C2_PERIODIC = 2;
  localparam int RTC_C2_WALARM = 1;
  localparam int RTC_C2_DALARM = 0;

  // Reset values
  localparam logic [7:0] RTC_CTRL1_RST = 8'h00;
  localparam logic [7:0] RTC_CTRL2_RST = 8'h10;
  localparam logic [7:0] RTC_ZERO = 8'h00;
  localparam logic [7:0] RTC_HOUR_RST = 8'h12;
  localparam logic [7:0] RTC_DAY_RST = 8'h01;
  localparam logic [7:0] RTC_KEEP_C2_MASK = 8'h30;

  // Timing
  localparam int RTC_CLK_HZ = 10_000_000;
  localparam int RTC_RELEASE_DELAY_MS = 100;
  localparam int RTC_RELEASE_DELAY_CYC = RTC_RELEASE_DELAY_MS * (RTC_CLK_HZ / 1000);
  localparam int RTC_OSC_TIMEOUT_US = 2000;
  localparam int RTC_OSC_TIMEOUT_CYC = RTC_OSC_TIMEOUT_US * (RTC_CLK_HZ / 1_000_000);

  // Periodic output modes in control register 1 order
  typedef enum logic [2:0] {
    RTC_PER_OFF, RTC_PER_LOW, RTC_PER_2HZ, RTC_PER_1HZ,
    RTC_PER_SEC, RTC_PER_MIN, RTC_PER_HOUR, RTC_PER_MONTH
  } rtc_psel_e;

  // Writable bits of each register; unused bits read zero, except control 1 bits 4 and 3 and control 2 bit 3
  function automatic logic [7:0] rtc_mask(input logic [3:0] a);
    case (a)
      4'h0, 4'h1, 4'h8, 4'hA, 4'hB: rtc_mask = 8'h7F;
      4'h2, 4'h4, 4'h9, 4'hC: rtc_mask = 8'h3F;
      4'h3: rtc_mask = 8'h07;
      4'h5: rtc_mask = 8'h9F;
      4'hD: rtc_mask = 8'h00;
      default: rtc_mask = 8'hFF;
    endcase
  endfunction

  // BCD increment of a two-digit value
  function automatic logic [7:0] rtc_bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9)
      rtc_bcd_inc = {v[7:4] + 4'h1, 4'h0};
    else
      rtc_bcd_inc = {v[7:4], v[3:0] + 4'h1};
  endfunction

endpackage

//--- src/rtc_core.sv
// Real-time clock counters, control registers and supervisory logic
`timescale 1ns/1ps
module rtc_core
  import rtc_pkg::*;
#(
  parameter int RELEASE_DELAY_CYC = RTC_RELEASE_DELAY_CYC,
  parameter int OSC_TIMEOUT_CYC = RTC_OSC_TIMEOUT_CYC
)
(
  // Host clock, reset and enable
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Crystal clock
  input wire logic i_xtal_clk,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_wr_busy,
  // Supply comparators
  input wire logic i_vcc_below_fall,
  input wire logic i_vcc_above_rise,
  input wire logic i_vdd_below_2v1,
  input wire logic i_vdd_below_1v35,
  // Pins
  output logic o_main_supply_low_n,
  output logic o_interrupt_out_n,
  output logic o_crystal_clock_out
);

  // Crystal-domain state
  typedef struct packed {
    logic ce_s1;               // Enable synchroniser
    logic ce_s2;
    logic req_s1;              // Write request toggle synchroniser
    logic req_s2;
    logic req_seen;            // Last request served, doubles as acknowledge
    logic fmt_s1;              // Hour format synchroniser
    logic fmt_s2;
    logic [14:0] div;          // Crystal divider
    logic [6:0][7:0] cnt;      // Time and calendar counters
    logic tick_tg;             // Toggles on each second increment
    logic upd_tg;              // Toggles whenever counters change
  } rtc_xs_s;

  // Host-domain state
  typedef struct packed {
    logic [3:0] wr_addr;       // Pending counter write
    logic [7:0] wr_data;
    logic wr_req;
    logic ack_s1;
    logic ack_s2;
    logic upd_s1;
    logic upd_s2;
    logic upd_seen;
    logic tick_s1;
    logic tick_s2;
    logic tick_seen;
    logic p2_s1;               // 2 Hz square wave synchroniser
    logic p2_s2;
    logic p1_s1;               // 1 Hz square wave synchroniser
    logic p1_s2;
    logic osc_s1;              // Oscillator activity synchroniser
    logic osc_s2;
    logic osc_seen;
    logic [19:0] osc_cnt;
    logic fall_s1;
    logic fall_s2;
    logic rise_s1;
    logic rise_s2;
    logic b21_s1;
    logic b21_s2;
    logic b135_s1;
    logic b135_s2;
    logic supply_low;          // Main supply detector state
    logic [19:0] dly_cnt;
    logic [6:0][7:0] shadow;   // Host copy of counters
    logic [7:0] trim;
    logic [7:0] wa_min;
    logic [7:0] wa_hour;
    logic [7:0] wa_days;
    logic [7:0] da_min;
    logic [7:0] da_hour;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic int_n;
    logic [7:0] rdata;
  } rtc_hs_s;

  rtc_xs_s xq, xd;
  rtc_hs_s hq, hd;

  // Days in a BCD month; years divisible by four are leap years
  function automatic logic [7:0] days_in_month(input logic [4:0] mon, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    case (mon)
      5'h02: days_in_month = leap ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: days_in_month = 8'h30;
      default: days_in_month = 8'h31;
    endcase
  endfunction

  // Crystal output is the oscillator itself, never gated
  assign o_crystal_clock_out = i_xtal_clk;

  // Crystal domain: divider, write service and calendar advance
  always_comb
  begin
    logic tick;
    logic carry;
    logic wr_now;
    tick = 1'b0;
    carry = 1'b0;
    wr_now = 1'b0;
    xd = xq;
    xd.ce_s1 = i_ce;
    xd.ce_s2 = xq.ce_s1;
    xd.req_s1 = hq.wr_req;
    xd.req_s2 = xq.req_s1;
    xd.fmt_s1 = hq.ctrl1[RTC_C1_HOUR24];
    xd.fmt_s2 = xq.fmt_s1;
    // Frozen while the enable is low
    if (xq.ce_s2)
    begin
      xd.div = xq.div + 15'h0001;
      tick = (xq.div == 15'h7FFF);
      // Second increment with carries up to the year
      if (tick)
      begin
        carry = (xq.cnt[0] == 8'h59);
        xd.cnt[0] = carry ? RTC_ZERO : rtc_bcd_inc(xq.cnt[0]);
        if (carry)
        begin
          carry = (xq.cnt[1] == 8'h59);
          xd.cnt[1] = carry ? RTC_ZERO : rtc_bcd_inc(xq.cnt[1]);
        end
        // Hour advance in the selected format
        if (carry)
        begin
          carry = 1'b0;
          if (xq.fmt_s2)
          begin
            carry = (xq.cnt[2] == 8'h23);
            xd.cnt[2] = carry ? RTC_ZERO : rtc_bcd_inc(xq.cnt[2]);
          end
          else
          begin
            case (xq.cnt[2])
              8'h11: xd.cnt[2] = 8'h32;
              8'h32: xd.cnt[2] = 8'h21;
              8'h12: xd.cnt[2] = 8'h01;
              8'h31:
              begin
                xd.cnt[2] = RTC_HOUR_RST;
                carry = 1'b1;
              end
              default: xd.cnt[2] = rtc_bcd_inc(xq.cnt[2]);
            endcase
          end
        end
        // Weekday, day of month, month and century
        if (carry)
        begin
          xd.cnt[3] = (xq.cnt[3] == 8'h06) ? RTC_ZERO : xq.cnt[3] + 8'h01;
          carry = (xq.cnt[4] == days_in_month(xq.cnt[5][4:0], xq.cnt[6]));
          xd.cnt[4] = carry ? RTC_DAY_RST : rtc_bcd_inc(xq.cnt[4]);
        end
        if (carry)
        begin
          carry = (xq.cnt[5][4:0] == 5'h12);
          xd.cnt[5] = carry ? {xq.cnt[5][7], 7'h01} : rtc_bcd_inc(xq.cnt[5]);
        end
        if (carry)
        begin
          xd.cnt[6] = (xq.cnt[6] == 8'h99) ? RTC_ZERO : rtc_bcd_inc(xq.cnt[6]);
          if (xq.cnt[6] == 8'h99)
            xd.cnt[5][7] = ~xq.cnt[5][7];
        end
        xd.tick_tg = ~xq.tick_tg;
      end
      // Host write lands after the increment so it always wins
      if (xq.req_s2 != xq.req_seen)
      begin
        wr_now = 1'b1;
        xd.req_seen = xq.req_s2;
        xd.cnt[hq.wr_addr[2:0]] = hq.wr_data & rtc_mask(hq.wr_addr);
        // Rewriting seconds restarts the sub-second divider
        if (hq.wr_addr == RTC_ADDR_SEC)
          xd.div = 15'h0000;
      end
      if (tick || wr_now)
        xd.upd_tg = ~xq.upd_tg;
    end
  end

  // Crystal-domain registers
  always_ff @(posedge i_xtal_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      xq <= '0;
      xq.cnt[2] <= RTC_HOUR_RST;
      xq.cnt[4] <= RTC_DAY_RST;
      xq.cnt[5] <= RTC_DAY_RST;
    end
    else
      xq <= xd;
  end

  // Host domain: register file, supervision and periodic output
  always_comb
  begin
    logic sec_ev;
    logic min_ev;
    logic hour_ev;
    logic month_ev;
    logic midnight;
    rtc_psel_e psel;
    sec_ev = 1'b0;
    min_ev = 1'b0;
    hour_ev = 1'b0;
    month_ev = 1'b0;
    midnight = 1'b0;
    psel = RTC_PER_OFF;
    hd = hq;
    // Synchronisers
    hd.ack_s1 = xq.req_seen;
    hd.ack_s2 = hq.ack_s1;
    hd.upd_s1 = xq.upd_tg;
    hd.upd_s2 = hq.upd_s1;
    hd.tick_s1 = xq.tick_tg;
    hd.tick_s2 = hq.tick_s1;
    hd.p2_s1 = xq.div[13];
    hd.p2_s2 = hq.p2_s1;
    hd.p1_s1 = xq.div[14];
    hd.p1_s2 = hq.p1_s1;
    hd.osc_s1 = xq.div[5];
    hd.osc_s2 = hq.osc_s1;
    hd.fall_s1 = i_vcc_below_fall;
    hd.fall_s2 = hq.fall_s1;
    hd.rise_s1 = i_vcc_above_rise;
    hd.rise_s2 = hq.rise_s1;
    hd.b21_s1 = i_vdd_below_2v1;
    hd.b21_s2 = hq.b21_s1;
    hd.b135_s1 = i_vdd_below_1v35;
    hd.b135_s2 = hq.b135_s1;
    // Counters are stable while their change toggle crosses; a second event also
    // refreshes the copy, covering a write whose toggle merged with the tick
    if (hq.upd_s2 != hq.upd_seen || hq.tick_s2 != hq.tick_seen)
    begin
      hd.upd_seen = hq.upd_s2;
      hd.shadow = xq.cnt;
    end
    // Second events and their coarser coincidences
    sec_ev = (hq.tick_s2 != hq.tick_seen);
    hd.tick_seen = hq.tick_s2;
    midnight = hq.ctrl1[RTC_C1_HOUR24] ? (xq.cnt[2] == RTC_ZERO) : (xq.cnt[2] == RTC_HOUR_RST);
    min_ev = sec_ev && (xq.cnt[0] == RTC_ZERO);
    hour_ev = min_ev && (xq.cnt[1] == RTC_ZERO);
    month_ev = hour_ev && midnight && (xq.cnt[4] == RTC_DAY_RST);
    psel = rtc_psel_e'(hq.ctrl1[RTC_C1_PSEL_MSB:0]);
    // Host writes; flags clear only on a written zero
    if (i_wr)
    begin
      case (i_addr)
        RTC_ADDR_SEC, RTC_ADDR_MIN, RTC_ADDR_HOUR, RTC_ADDR_WDAY,
        RTC_ADDR_MDAY, RTC_ADDR_MON, RTC_ADDR_YEAR:
        begin
          // Counter writes cross by request toggle; refused while one is pending
          if (hq.wr_req == hq.ack_s2)
          begin
            hd.wr_addr = i_addr;
            hd.wr_data = i_wdata;
            hd.wr_req = ~hq.wr_req;
          end
        end
        RTC_ADDR_TRIM: hd.trim = i_wdata;
        RTC_ADDR_WA_MIN: hd.wa_min = i_wdata & rtc_mask(i_addr);
        RTC_ADDR_WA_HOUR: hd.wa_hour = i_wdata & rtc_mask(i_addr);
        RTC_ADDR_WA_DAYS: hd.wa_days = i_wdata & rtc_mask(i_addr);
        RTC_ADDR_DA_MIN: hd.da_min = i_wdata & rtc_mask(i_addr);
        RTC_ADDR_DA_HOUR: hd.da_hour = i_wdata & rtc_mask(i_addr);
        RTC_ADDR_CTRL1: hd.ctrl1 = i_wdata;
        RTC_ADDR_CTRL2:
        begin
          hd.ctrl2[RTC_C2_THR_SEL] = i_wdata[RTC_C2_THR_SEL];
          hd.ctrl2[RTC_C2_OSC_RUN] = i_wdata[RTC_C2_OSC_RUN];
          hd.ctrl2[3] = i_wdata[3];
          hd.ctrl2[RTC_C2_SUPPLY_LOW] = hq.ctrl2[RTC_C2_SUPPLY_LOW] & i_wdata[RTC_C2_SUPPLY_LOW];
          hd.ctrl2[RTC_C2_PON] = hq.ctrl2[RTC_C2_PON] & i_wdata[RTC_C2_PON];
          hd.ctrl2[2:0] = hq.ctrl2[2:0] & i_wdata[2:0];
        end
        default:
        begin
          // Reserved slot ignores writes
        end
      endcase
    end
    // Oscillator watchdog; a halt clears the running flag and it stays clear
    if (hq.osc_s2 != hq.osc_seen)
      hd.osc_cnt = '0;
    else if (hq.osc_cnt != 20'(OSC_TIMEOUT_CYC))
      hd.osc_cnt = hq.osc_cnt + 20'h0_0001;
    hd.osc_seen = hq.osc_s2;
    if (hq.osc_cnt == 20'(OSC_TIMEOUT_CYC))
      hd.ctrl2[RTC_C2_OSC_RUN] = 1'b0;
    // Supply monitor samples once per second until a drop is latched
    if (sec_ev && !hq.ctrl2[RTC_C2_SUPPLY_LOW])
    begin
      if (hq.ctrl2[RTC_C2_THR_SEL] ? hq.b135_s2 : hq.b21_s2)
        hd.ctrl2[RTC_C2_SUPPLY_LOW] = 1'b1;
    end
    // Alarms compare at the top of each minute
    if (min_ev && hq.ctrl1[RTC_C1_WALARM_EN] && xq.cnt[1] == hq.wa_min
        && xq.cnt[2] == hq.wa_hour && hq.wa_days[xq.cnt[3][2:0]])
      hd.ctrl2[RTC_C2_WALARM] = 1'b1;
    if (min_ev && hq.ctrl1[RTC_C1_DALARM_EN] && xq.cnt[1] == hq.da_min && xq.cnt[2] == hq.da_hour)
      hd.ctrl2[RTC_C2_DALARM] = 1'b1;
    // Periodic condition: waveform in pulse modes, sticky in level modes
    case (psel)
      RTC_PER_2HZ: hd.ctrl2[RTC_C2_PERIODIC] = ~hq.p2_s2;
      RTC_PER_1HZ: hd.ctrl2[RTC_C2_PERIODIC] = ~hq.p1_s2;
      RTC_PER_SEC: hd.ctrl2[RTC_C2_PERIODIC] = hd.ctrl2[RTC_C2_PERIODIC] | sec_ev;
      RTC_PER_MIN: hd.ctrl2[RTC_C2_PERIODIC] = hd.ctrl2[RTC_C2_PERIODIC] | min_ev;
      RTC_PER_HOUR: hd.ctrl2[RTC_C2_PERIODIC] = hd.ctrl2[RTC_C2_PERIODIC] | hour_ev;
      RTC_PER_MONTH: hd.ctrl2[RTC_C2_PERIODIC] = hd.ctrl2[RTC_C2_PERIODIC] | month_ev;
      default: hd.ctrl2[RTC_C2_PERIODIC] = 1'b0;
    endcase
    // Power-on state holds trim and control 1 at zero, keeping only oscillator run and power-on in control 2
    if (hd.ctrl2[RTC_C2_PON])
    begin
      hd.trim = RTC_ZERO;
      hd.ctrl1 = RTC_ZERO;
      hd.ctrl2 = hd.ctrl2 & RTC_KEEP_C2_MASK;
    end
    // Interrupt pin low on any enabled condition
    hd.int_n = ~((psel == RTC_PER_LOW) || hq.ctrl2[RTC_C2_PERIODIC]
                 || (hq.ctrl1[RTC_C1_WALARM_EN] && hq.ctrl2[RTC_C2_WALARM])
                 || (hq.ctrl1[RTC_C1_DALARM_EN] && hq.ctrl2[RTC_C2_DALARM]));
    // Main supply detector with release delay
    if (hq.fall_s2)
    begin
      hd.supply_low = 1'b1;
      hd.dly_cnt = '0;
    end
    else if (hq.supply_low && hq.rise_s2)
    begin
      hd.dly_cnt = hq.dly_cnt + 20'h0_0001;
      if (hq.dly_cnt >= 20'(RELEASE_DELAY_CYC - 1))
        hd.supply_low = 1'b0;
    end
    else
      hd.dly_cnt = '0;
    // Read data registered from the address
    case (i_addr)
      RTC_ADDR_SEC, RTC_ADDR_MIN, RTC_ADDR_HOUR, RTC_ADDR_WDAY,
      RTC_ADDR_MDAY, RTC_ADDR_MON, RTC_ADDR_YEAR: hd.rdata = hq.shadow[i_addr[2:0]];
      RTC_ADDR_TRIM: hd.rdata = hq.trim;
      RTC_ADDR_WA_MIN: hd.rdata = hq.wa_min;
      RTC_ADDR_WA_HOUR: hd.rdata = hq.wa_hour;
      RTC_ADDR_WA_DAYS: hd.rdata = hq.wa_days;
      RTC_ADDR_DA_MIN: hd.rdata = hq.da_min;
      RTC_ADDR_DA_HOUR: hd.rdata = hq.da_hour;
      RTC_ADDR_CTRL1: hd.rdata = hq.ctrl1;
      RTC_ADDR_CTRL2: hd.rdata = hq.ctrl2;
      default: hd.rdata = RTC_ZERO;
    endcase
  end

  // Host-domain registers; power-on sets the flag and records a halt
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      hq <= '0;
      hq.ctrl1 <= RTC_CTRL1_RST;
      hq.ctrl2 <= RTC_CTRL2_RST;
      hq.shadow[2] <= RTC_HOUR_RST;
      hq.shadow[4] <= RTC_DAY_RST;
      hq.shadow[5] <= RTC_DAY_RST;
      hq.int_n <= 1'b1;
      hq.supply_low <= 1'b1;
    end
    else if (i_ce)
      hq <= hd;
  end

  // Outputs
  assign o_rdata = hq.rdata;
  assign o_wr_busy = (hq.wr_req != hq.ack_s2);
  assign o_main_supply_low_n = ~hq.supply_low;
  assign o_interrupt_out_n = hq.int_n;

endmodule

//--- test/rtc_core_chk.sv
// Port-level concurrent checks for the real-time clock core
`timescale 1ns/1ps
module rtc_core_chk
  import rtc_pkg::*;
#(
  parameter int RELEASE_DELAY_CYC = 20
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Watched inputs
  input wire logic i_xtal_clk,
  input wire logic [3:0] i_addr,
  input wire logic i_vcc_below_fall,
  input wire logic i_vcc_above_rise,
  // Watched outputs
  input wire logic [7:0] o_rdata,
  input wire logic o_wr_busy,
  input wire logic o_main_supply_low_n,
  input wire logic o_interrupt_out_n,
  input wire logic o_crystal_clock_out
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // Run length of the rising comparator, saturating at the delay
  int rise_q;

  // Count consecutive cycles with the supply above the rising threshold
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rise_q <= 0;
    else if (!i_vcc_above_rise)
      rise_q <= 0;
    else if (rise_q < RELEASE_DELAY_CYC)
      rise_q <= rise_q + 1;
  end

  AST_CRYSTAL_CLOCK_OUT_PASS: assert property (o_crystal_clock_out == i_xtal_clk)
    else $error("crystal clock output differs from crystal");
  AST_SUPPLY_LOW: assert property (i_vcc_below_fall [*4] |-> !o_main_supply_low_n)
    else $error("supply low output not driven low");
  AST_SUPPLY_RELEASE: assert property ($rose(o_main_supply_low_n) |-> rise_q >= RELEASE_DELAY_CYC)
    else $error("supply low output released too early");
  AST_SEC_TOP_ZERO: assert property ($past(i_addr) == RTC_ADDR_SEC |-> o_rdata[7] == 1'b0)
    else $error("seconds bit 7 not zero");
  AST_HOUR_TOP_ZERO: assert property ($past(i_addr) == RTC_ADDR_HOUR |-> o_rdata[7:6] == 2'b00)
    else $error("hour upper bits not zero");
  AST_WDAY_TOP_ZERO: assert property ($past(i_addr) == RTC_ADDR_WDAY |-> o_rdata[7:3] == 5'h00)
    else $error("weekday upper bits not zero");
  AST_MONTH_GAP_ZERO: assert property ($past(i_addr) == RTC_ADDR_MON |-> o_rdata[6:5] == 2'b00)
    else $error("month bits 6 and 5 not zero");
  AST_RSVD_ZERO: assert property ($past(i_addr) == 4'hD |-> o_rdata == 8'h00)
    else $error("reserved slot not zero");
  AST_BUSY_ENDS: assert property ($rose(o_wr_busy) |-> ##[1:60] !o_wr_busy)
    else $error("counter write crossing did not finish");
  AST_PERIODIC_OFF: assert property ($past(i_addr, 2) == RTC_ADDR_CTRL1 && $past(i_addr) == RTC_ADDR_CTRL1
    && $past(o_rdata) == o_rdata && o_rdata[7:6] == 2'b00 && o_rdata[2:0] == 3'd0 |-> o_interrupt_out_n)
    else $error("interrupt pin low with periodic output off");
  AST_PERIODIC_LOW: assert property ($past(i_addr, 2) == RTC_ADDR_CTRL1 && $past(i_addr) == RTC_ADDR_CTRL1
    && $past(o_rdata) == o_rdata && o_rdata[2:0] == 3'd1 |-> !o_interrupt_out_n)
    else $error("interrupt pin not held low");
endmodule

bind rtc_core rtc_core_chk #(.RELEASE_DELAY_CYC(RELEASE_DELAY_CYC)) i_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_xtal_clk(i_xtal_clk), .i_addr(i_addr),
  .i_vcc_below_fall(i_vcc_below_fall), .i_vcc_above_rise(i_vcc_above_rise), .o_rdata(o_rdata),
  .o_wr_busy(o_wr_busy), .o_main_supply_low_n(o_main_supply_low_n), .o_interrupt_out_n(o_interrupt_out_n),
  .o_crystal_clock_out(o_crystal_clock_out));

//--- test/rtc_host_model.sv
// Host-side model that drives the core's parallel register port
`timescale 1ns/1ps
module rtc_host_model
  import rtc_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Answers from the core
  input wire logic [7:0] i_rdata,
  input wire logic i_wr_busy,
  // Requests to the core
  output logic [3:0] o_addr,
  output logic o_wr,
  output logic [7:0] o_wdata
);
  // Idle port at time zero
  initial
  begin
    o_addr = 4'h0;
    o_wr = 1'b0;
    o_wdata = 8'h00;
  end

  // One-cycle write strobe; counter writes wait out the crossing
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    // Data no longer qualified, so show something else
    o_wdata = ~d;
    while (i_wr_busy === 1'b1 && n < 100)
    begin
      @(negedge i_clk);
      n++;
    end
    // A crossing that never ends fails the run
    if (n == 100)
      rtc_core_tb_top.err_total++;
    // Counter value lands in the shadow a few cycles later
    if (a < RTC_ADDR_TRIM)
      repeat (6) @(negedge i_clk);
  endtask

  // Address held, registered data taken once settled
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    repeat (2) @(negedge i_clk);
    d = i_rdata;
  endtask
endmodule

//--- test/rtc_core_tb_top.sv
// Self-checking bench for the real-time clock core
`timescale 1ns/1ps
module rtc_core_tb_top
  import rtc_pkg::*;
();
  // Clocks, reset and comparator inputs
  logic clk = 1'b0;
  logic xtal_clk = 1'b0;
  logic xtal_run = 1'b1;
  logic rst_n = 1'b0;
  logic vcc_fall = 1'b0;
  logic vcc_rise = 1'b0;
  logic vdd_2v1 = 1'b0;
  logic vdd_1v35 = 1'b0;
  // Register port and pins
  logic [3:0] addr;
  logic wr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wr_busy;
  logic supply_low_n;
  logic int_n;
  logic clk_out;
  // Bookkeeping
  int err_total = 0;
  int n_compared = 0;
  int lows = 0;
  logic [7:0] v;
  // Read-back of all ones per register, addresses 7 to E
  logic [7:0] wmask [7:14] = '{8'hFF, 8'h7F, 8'h3F, 8'h7F, 8'h7F, 8'h3F, 8'h00, 8'hFF};

  // Host clock, 100 ns period
  always #50 clk = ~clk;

  // Crystal clock, 6 ns period, odd phase, stops while halted
  initial
  begin
    #1.3;
    forever #3 if (xtal_run) xtal_clk = ~xtal_clk;
  end

  rtc_core #(.RELEASE_DELAY_CYC(20), .OSC_TIMEOUT_CYC(50)) i_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_xtal_clk(xtal_clk), .i_addr(addr), .i_wr(wr),
    .i_wdata(wdata), .o_rdata(rdata), .o_wr_busy(wr_busy), .i_vcc_below_fall(vcc_fall),
    .i_vcc_above_rise(vcc_rise), .i_vdd_below_2v1(vdd_2v1), .i_vdd_below_1v35(vdd_1v35),
    .o_main_supply_low_n(supply_low_n), .o_interrupt_out_n(int_n), .o_crystal_clock_out(clk_out));

  rtc_host_model i_host (
    .i_clk(clk), .i_rdata(rdata), .i_wr_busy(wr_busy), .o_addr(addr), .o_wr(wr), .o_wdata(wdata));

  // Compare and count
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Read a register and compare the masked bits
  task automatic rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e, input string name);
    i_host.rd(a, v);
    chk(name, v & m, e);
  endtask

  // Verdict and end of run
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Set a time one second before a minute carry, then check the carry
  task automatic roll(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] h,
    input logic [7:0] eh, input logic [7:0] ed, input logic [7:0] e2);
    i_host.wr(RTC_ADDR_CTRL1, c1);
    i_host.wr(RTC_ADDR_CTRL2, c2);
    i_host.wr(RTC_ADDR_MDAY, 8'h01);
    i_host.wr(RTC_ADDR_HOUR, h);
    i_host.wr(RTC_ADDR_MIN, 8'h59);
    i_host.wr(RTC_ADDR_SEC, 8'h59);
    repeat (2500) @(negedge clk);
    rc(RTC_ADDR_SEC, 8'hFF, 8'h00, "sec");
    rc(RTC_ADDR_MIN, 8'hFF, 8'h00, "min");
    rc(RTC_ADDR_HOUR, 8'hFF, eh, "hour");
    rc(RTC_ADDR_MDAY, 8'hFF, ed, "mday");
    rc(RTC_ADDR_CTRL2, 8'h45, e2, "ctrl2 flags");
    chk("int_n set", {7'h00, int_n}, 8'h00);
    i_host.wr(RTC_ADDR_CTRL2, c2 & 8'h80);
    repeat (2) @(negedge clk);
    chk("int_n clear", {7'h00, int_n}, 8'h01);
    $display("test roll done");
  endtask

  // Watchdog well beyond the expected run of about 7500 cycles
  initial
  begin
    #2_000_000;
    err_total++;
    results();
  end

  // Main sequence
  initial
  begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    chk("supply_low_n rst", {7'h00, supply_low_n}, 8'h00);
    rc(RTC_ADDR_CTRL2, 8'hFF, 8'h10, "ctrl2 rst");
    rc(RTC_ADDR_CTRL1, 8'hFF, 8'h00, "ctrl1 rst");
    i_host.wr(RTC_ADDR_CTRL1, 8'hFF);
    i_host.wr(RTC_ADDR_TRIM, 8'hFF);
    rc(RTC_ADDR_CTRL1, 8'hFF, 8'h00, "ctrl1 pon");
    rc(RTC_ADDR_TRIM, 8'hFF, 8'h00, "trim pon");
    i_host.wr(RTC_ADDR_CTRL2, 8'h1F);
    rc(RTC_ADDR_CTRL2, 8'hDF, 8'h10, "pon keep");
    i_host.wr(RTC_ADDR_CTRL2, 8'h00);
    rc(RTC_ADDR_CTRL2, 8'hDF, 8'h00, "pon clear");
    $display("test power_on done");
    // All ones into every non-counter register except control register 2
    for (int a = 7; a < 15; a++)
    begin
      i_host.wr(a[3:0], 8'hFF);
      rc(a[3:0], 8'hFF, wmask[a], "rw mask");
    end
    i_host.wr(RTC_ADDR_WDAY, 8'hFE);
    rc(RTC_ADDR_WDAY, 8'hFF, 8'h06, "wday");
    i_host.wr(RTC_ADDR_MON, 8'hF2);
    rc(RTC_ADDR_MON, 8'hFF, 8'h92, "month");
    i_host.wr(RTC_ADDR_YEAR, 8'h99);
    rc(RTC_ADDR_YEAR, 8'hFF, 8'h99, "year");
    $display("test masks done");
    // Periodic output off, then held low
    for (int m = 0; m < 2; m++)
    begin
      i_host.wr(RTC_ADDR_CTRL1, m[7:0]);
      rc(RTC_ADDR_CTRL1, 8'hFF, m[7:0], "ctrl1 mode");
      repeat (3) @(negedge clk);
      chk("int_n mode", {7'h00, int_n}, (m == 0) ? 8'h01 : 8'h00);
    end
    $display("test periodic done");
    // Main supply detector release delay and fall
    vcc_rise = 1'b1;
    repeat (10) @(negedge clk);
    chk("supply early", {7'h00, supply_low_n}, 8'h00);
    repeat (20) @(negedge clk);
    chk("supply released", {7'h00, supply_low_n}, 8'h01);
    vcc_fall = 1'b1;
    vcc_rise = 1'b0;
    repeat (5) @(negedge clk);
    chk("supply fall", {7'h00, supply_low_n}, 8'h00);
    vcc_fall = 1'b0;
    $display("test detector done");
    // Minute carries, supply sampled against 2.1 V then 1.35 V
    vdd_2v1 = 1'b1;
    roll(8'h05, 8'h00, 8'h11, 8'h32, 8'h01, 8'h44);
    // Daily alarm at midnight; supply now below 1.35 V only
    i_host.wr(RTC_ADDR_DA_MIN, 8'h00);
    i_host.wr(RTC_ADDR_DA_HOUR, 8'h00);
    vdd_2v1 = 1'b0;
    vdd_1v35 = 1'b1;
    roll(8'h65, 8'h80, 8'h23, 8'h00, 8'h02, 8'h45);
    // 2 Hz pulses: pin low for half of each period over one second
    i_host.wr(RTC_ADDR_CTRL1, 8'h02);
    repeat (1966)
    begin
      @(negedge clk);
      lows += int'(!int_n);
    end
    chk("2hz low cycles", 8'(lows > 970 && lows < 996), 8'h01);
    $display("test pulse done");
    // Oscillator halt leaves a sticky record
    i_host.wr(RTC_ADDR_CTRL2, 8'h20);
    rc(RTC_ADDR_CTRL2, 8'h20, 8'h20, "osc run");
    xtal_run = 1'b0;
    repeat (100) @(negedge clk);
    xtal_run = 1'b1;
    repeat (100) @(negedge clk);
    rc(RTC_ADDR_CTRL2, 8'h20, 8'h00, "osc halt");
    $display("test osc_halt done");
    results();
  end
endmodule
